// ### ssrs_pkg.sv
// Package with constants for the stereo setup, reset and standby block
package ssrs_pkg;
    localparam int SSRS_CLK_PERIOD_PS = 4000;
    localparam int SSRS_RST_MIN_NS = 750;
    localparam int SSRS_RST_MIN_CYC = (SSRS_RST_MIN_NS * 1000 + SSRS_CLK_PERIOD_PS - 1)
        / SSRS_CLK_PERIOD_PS;
    localparam int SSRS_BUS_WAIT_CYC = 10;
    localparam int SSRS_SHIFT_MULT = 18;
    localparam int SSRS_STBY_GUARD_ROWS = 5;
    localparam int SSRS_PIX_HI = 9;
    localparam int SSRS_PIX_LO = 2;
    localparam logic SSRS_ADDR_FIXED_BIT = 1'h1;
    localparam logic [9:0] SSRS_RST_VBLANK = 10'h02D;
    localparam logic [7:0] SSRS_SYNC_CODE = 8'hFF;
    typedef enum logic [1:0] {
        SSRS_RUN = 2'b00,
        SSRS_DRAIN = 2'b01,
        SSRS_STANDBY = 2'b10,
        SSRS_LOCKED = 2'b11
    } ssrs_state_e;
endpackage

// ### ssrs_serializer.sv
// Shift-tick divider and stereo serial word shifter
`timescale 1ns/100ps
module ssrs_serializer
    import ssrs_pkg::*;
#(
    parameter int WORD_W = 18
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic en,
    input wire logic [WORD_W-1:0] word_in,
    output logic word_take,
    output logic bit_out
);
    logic [WORD_W-1:0] sh_q;
    logic [4:0] cnt_q;
    wire last_bit = (cnt_q == 5'(WORD_W - 1));
    assign word_take = en && last_bit;

    // One bit per slot, word reloaded every WORD_W slots, aligned to the release of rst or rise of en
    always_ff @(posedge clk) begin
        if (rst || !en) begin
            cnt_q <= 5'h00;
            sh_q <= '0;
            bit_out <= 1'h0;
        end else begin
            cnt_q <= last_bit ? 5'h00 : cnt_q + 5'h01;
            sh_q <= last_bit ? word_in : {sh_q[WORD_W-2:0], 1'h0};
            bit_out <= sh_q[WORD_W-1];
        end
    end

    a_word_period: assert property (@(posedge clk) disable iff (rst)
        word_take |=> !word_take [*8])
        else $error("word reload too early");
endmodule

// ### ssrs_top.sv
// Stereo setup, hardware reset and standby control of the image sensor
`timescale 1ns/100ps
//
// Contract
// - Serial shift rate is eighteen slots per system clock word, aligned.
// - Stream carries pixel bits 9:2 with embedded row and frame strobes.
// - Mismatch flag sets when master and slave reserved codes differ.
// - Bus address has one fixed bit, one bit from select input.
// - Outputs defined during reset; reset is not a low power state.
// - Standby entered only after current frame readout finishes.
// - In standby video outputs float and serial bus is ignored.
// - Standby request in dead zone may lock standby until hardware reset.
module ssrs_top
    import ssrs_pkg::*;
#(
    parameter int PIX_W = 10,
    parameter int VB_W = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic standby_req,
    input wire logic stereo_en,
    input wire logic stereo_slave,
    input wire logic soft_reset,
    input wire logic bus_id_sel,
    input wire logic [6:0] bus_addr_base,
    input wire logic [VB_W-1:0] vblank_rows,
    input wire logic row_tick,
    input wire logic frame_active,
    input wire logic row_active,
    input wire logic [PIX_W-1:0] pixel_in,
    input wire logic [7:0] local_check_code,
    input wire logic [7:0] peer_check_code,
    input wire logic check_strobe,
    input wire logic mismatch_clear,
    output logic [1:0] bus_addr,
    output logic bus_respond_en,
    output logic video_oe,
    output logic [PIX_W-1:0] video_data,
    output logic frame_strobe_out,
    output logic row_strobe_out,
    output logic serial_video_pos,
    output logic serial_video_neg,
    output logic serial_oe,
    output logic in_standby,
    output logic standby_locked,
    output logic lockstep_mismatch,
    output logic bus_ready
);
    ssrs_state_e state_q, state_d;
    logic frame_q;
    logic [VB_W:0] vb_cnt_q;
    logic in_vblank_q;
    logic [3:0] boot_cnt_q;
    logic mism_q;
    logic [PIX_W-1:0] pix_q;
    logic frame_o_q, row_o_q;
    logic ser_bit;
    logic word_take;
    logic [17:0] ser_word_q;

    wire frame_fall = frame_q && !frame_active;
    wire frame_rise = !frame_q && frame_active;
    // Dead zone: within +/-5 rows of the programmed blanking end
    wire [VB_W:0] vb_ext = {1'h0, vblank_rows};
    wire [VB_W:0] dz_lo = (vb_ext > (VB_W+1)'(SSRS_STBY_GUARD_ROWS)) ?
        vb_ext - (VB_W+1)'(SSRS_STBY_GUARD_ROWS) : '0;
    wire [VB_W:0] dz_hi = vb_ext + (VB_W+1)'(SSRS_STBY_GUARD_ROWS);
    wire in_dead_zone = in_vblank_q && (vb_cnt_q >= dz_lo) && (vb_cnt_q <= dz_hi);
    wire stby_active = (state_q == SSRS_STANDBY) || (state_q == SSRS_LOCKED);

    // Address: one fixed bit, one from the select input
    assign bus_addr = {SSRS_ADDR_FIXED_BIT, bus_id_sel};
    assign bus_ready = (boot_cnt_q == 4'(SSRS_BUS_WAIT_CYC));
    assign bus_respond_en = bus_ready && !stby_active;
    assign video_oe = !stby_active;
    assign serial_oe = stereo_en && !stby_active && !rst;
    assign in_standby = stby_active;
    assign standby_locked = (state_q == SSRS_LOCKED);
    assign lockstep_mismatch = mism_q;
    assign video_data = pix_q;
    assign frame_strobe_out = frame_o_q;
    assign row_strobe_out = row_o_q;
    assign serial_video_pos = ser_bit;
    assign serial_video_neg = !ser_bit;

    always_comb begin
        state_d = state_q;
        case (state_q)
            SSRS_RUN: begin
                if (standby_req && in_dead_zone) begin
                    state_d = SSRS_LOCKED;
                end else if (standby_req) begin
                    state_d = frame_active ? SSRS_DRAIN : SSRS_STANDBY;
                end
            end
            SSRS_DRAIN: begin
                if (frame_fall) begin
                    state_d = SSRS_STANDBY;
                end
            end
            SSRS_STANDBY: begin
                if (!standby_req) begin
                    state_d = SSRS_RUN;
                end
            end
            SSRS_LOCKED: state_d = SSRS_LOCKED;
            default: state_d = SSRS_RUN;
        endcase
    end

    // Reset defines every output and leaves the part powered
    always_ff @(posedge clk) begin
        if (rst || soft_reset) begin
            state_q <= (rst || state_q != SSRS_LOCKED) ? SSRS_RUN : SSRS_LOCKED;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            boot_cnt_q <= 4'h0;
        end else if (boot_cnt_q != 4'(SSRS_BUS_WAIT_CYC)) begin
            boot_cnt_q <= boot_cnt_q + 4'h1;
        end
    end

    // Row count since frame end
    always_ff @(posedge clk) begin
        if (rst) begin
            frame_q <= 1'h0;
            in_vblank_q <= 1'h0;
            vb_cnt_q <= '0;
        end else begin
            frame_q <= frame_active;
            if (frame_fall) begin
                in_vblank_q <= 1'h1;
                vb_cnt_q <= '0;
            end else if (frame_rise) begin
                in_vblank_q <= 1'h0;
            end else if (row_tick && in_vblank_q && vb_cnt_q != '1) begin
                vb_cnt_q <= vb_cnt_q + (VB_W+1)'(1);
            end
        end
    end

    // Mismatch flag, a new mismatch wins over a clear
    always_ff @(posedge clk) begin
        if (rst) begin
            mism_q <= 1'h0;
        end else if (check_strobe && (local_check_code != peer_check_code)) begin
            mism_q <= 1'h1;
        end else if (mismatch_clear || soft_reset) begin
            mism_q <= 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || stby_active) begin
            pix_q <= '0;
            frame_o_q <= 1'h0;
            row_o_q <= 1'h0;
        end else begin
            pix_q <= pixel_in;
            frame_o_q <= frame_active;
            row_o_q <= row_active;
        end
    end

    // Pixel bits 9:2 plus embedded strobes, framed with start/stop markers
    always_ff @(posedge clk) begin
        if (rst) begin
            ser_word_q <= '0;
        end else if (word_take) begin
            ser_word_q <= {1'h1, frame_active, row_active,
                pixel_in[SSRS_PIX_HI:SSRS_PIX_LO], stereo_slave, 5'h00, 1'h0};
        end
    end

    ssrs_serializer #(
        .WORD_W(SSRS_SHIFT_MULT)
    ) u_ser (
        .clk(clk),
        .rst(rst),
        .en(serial_oe),
        .word_in(ser_word_q),
        .word_take(word_take),
        .bit_out(ser_bit)
    );

    a_mismatch_set: assert property (@(posedge clk) disable iff (rst)
        check_strobe && (local_check_code != peer_check_code) |=> lockstep_mismatch)
        else $error("mismatch not flagged");
    a_drain_frame: assert property (@(posedge clk) disable iff (rst || soft_reset)
        (state_q == SSRS_DRAIN) && frame_active |=> !in_standby)
        else $error("standby before frame end");
    a_standby_hiz: assert property (@(posedge clk) disable iff (rst)
        in_standby |-> !video_oe && !bus_respond_en && !serial_oe)
        else $error("outputs driven in standby");
    a_lock_sticky: assert property (@(posedge clk) disable iff (rst)
        standby_locked |=> standby_locked && in_standby)
        else $error("locked standby left without reset");
    a_bus_wait: assert property (@(posedge clk)
        rst |=> !bus_ready [*8])
        else $error("bus ready too early");
    a_addr_map: assert property (@(posedge clk) disable iff (rst)
        bus_addr == {SSRS_ADDR_FIXED_BIT, bus_id_sel})
        else $error("bus address wrong");
    a_reset_state: assert property (@(posedge clk)
        rst |=> !in_standby && video_oe)
        else $error("reset left low power state");
    a_video_pipe: assert property (@(posedge clk) disable iff (rst)
        !in_standby && !$past(in_standby) && !$past(rst) |->
        video_data == $past(pixel_in))
        else $error("video data not registered");
    c_drain: cover property (@(posedge clk) (state_q == SSRS_DRAIN) ##[1:1000] in_standby);
    c_lock: cover property (@(posedge clk) standby_locked);
    c_mism: cover property (@(posedge clk) lockstep_mismatch ##1 !lockstep_mismatch);
endmodule

// ### ssrs_host_model.sv
// Host model driving hardware reset and standby request
`timescale 1ns/100ps
module ssrs_host_model
    import ssrs_pkg::*;
#(
    parameter int HOLD_CYC = SSRS_RST_MIN_CYC
) (
    input wire logic clk,
    output logic rst,
    output logic bus_ok,
    output logic standby_req
);
    int wait_q;
    initial begin
        rst = 1'h1;
        standby_req = 1'h0;
        bus_ok = 1'h0;
    end
    // Bus use only after ten edges past release
    always @(posedge clk) begin
        if (rst) wait_q <= 0;
        else if (wait_q < SSRS_BUS_WAIT_CYC) wait_q <= wait_q + 1;
        bus_ok <= !rst && wait_q >= SSRS_BUS_WAIT_CYC - 1;
    end
    task automatic hw_reset(input int cycles);
        int n;
        n = (cycles < HOLD_CYC) ? HOLD_CYC : cycles;
        @(posedge clk);
        #1;
        rst = 1'h1;
        repeat (n) @(posedge clk);
        #1;
        rst = 1'h0;
    endtask
    task automatic set_standby(input logic level);
        @(posedge clk);
        #1;
        standby_req = level;
    endtask
endmodule

// ### ssrs_top_tb.sv
// Self-checking bench for the stereo setup, reset and standby block
`timescale 1ns/100ps
module ssrs_top_tb;
    import ssrs_pkg::*;
    logic clk = 1'h0, rst, standby_req, bus_ok, stereo_en = 1'h1, stereo_slave = 1'h1;
    logic soft_reset = 1'h0, bus_id_sel = 1'h0, row_tick = 1'h0, frame_active = 1'h0;
    logic row_active = 1'h0, check_strobe = 1'h0, mismatch_clear = 1'h0;
    logic [9:0] vblank_rows = 10'h008, pixel_in = 10'h3FF, video_data;
    logic [7:0] local_check_code = 8'h00, peer_check_code = 8'h00;
    logic [1:0] bus_addr;
    logic bus_respond_en, video_oe, frame_strobe_out, row_strobe_out, serial_video_pos;
    logic serial_video_neg, serial_oe, in_standby, standby_locked, lockstep_mismatch, bus_ready;
    logic [63:0] sh;
    logic found;
    int miscompares = 0, checked = 0;
    localparam logic [17:0] WORD = {1'h1, 1'h1, 1'h1, 8'hFF, 1'h1, 5'h00, 1'h0};
    localparam logic [0:3][19:0] ROWS = {{1'h0, 8'h5A, 8'h5A, SSRS_ADDR_FIXED_BIT, 1'h0, 1'h0},
        {1'h1, 8'h5A, 8'hA5, SSRS_ADDR_FIXED_BIT, 1'h1, 1'h1},
        {1'h1, 8'hC3, 8'hC3, SSRS_ADDR_FIXED_BIT, 1'h1, 1'h0},
        {1'h0, 8'h00, 8'h80, SSRS_ADDR_FIXED_BIT, 1'h0, 1'h1}};
    always #2 clk = ~clk;
    ssrs_host_model ssrs_host_model_inst (.clk(clk), .rst(rst), .bus_ok(bus_ok),
        .standby_req(standby_req));
    ssrs_top ssrs_top_inst (.clk(clk), .rst(rst), .standby_req(standby_req),
        .stereo_en(stereo_en), .stereo_slave(stereo_slave), .soft_reset(soft_reset),
        .bus_id_sel(bus_id_sel), .bus_addr_base(7'h00), .vblank_rows(vblank_rows),
        .row_tick(row_tick), .frame_active(frame_active), .row_active(row_active),
        .pixel_in(pixel_in), .local_check_code(local_check_code),
        .peer_check_code(peer_check_code), .check_strobe(check_strobe),
        .mismatch_clear(mismatch_clear), .bus_addr(bus_addr), .bus_respond_en(bus_respond_en),
        .video_oe(video_oe), .video_data(video_data), .frame_strobe_out(frame_strobe_out),
        .row_strobe_out(row_strobe_out), .serial_video_pos(serial_video_pos),
        .serial_video_neg(serial_video_neg), .serial_oe(serial_oe), .in_standby(in_standby),
        .standby_locked(standby_locked), .lockstep_mismatch(lockstep_mismatch),
        .bus_ready(bus_ready));
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        step(3);
        chk(12'({video_oe, in_standby, lockstep_mismatch, serial_oe}), 12'h008);
        ssrs_host_model_inst.hw_reset(4);
        step(9);
        chk(12'(bus_ready), 12'h000);
        step(2);
        chk(12'({bus_ready, bus_respond_en, bus_ok}), 12'h007);
        for (int i = 0; i < 4; i++) begin
            bus_id_sel = ROWS[i][19];
            local_check_code = ROWS[i][18:11];
            peer_check_code = ROWS[i][10:3];
            check_strobe = 1'h1;
            step(1);
            check_strobe = 1'h0;
            chk(12'(bus_addr), 12'(ROWS[i][2:1]));
            chk(12'(lockstep_mismatch), 12'(ROWS[i][0]));
            mismatch_clear = 1'h1;
            step(1);
            mismatch_clear = 1'h0;
        end
        step(1);
        // Mismatch and clear in one cycle: the set must win
        local_check_code = 8'h11;
        check_strobe = 1'h1;
        mismatch_clear = 1'h1;
        step(1);
        check_strobe = 1'h0;
        mismatch_clear = 1'h0;
        chk(12'(lockstep_mismatch), 12'h001);
        soft_reset = 1'h1;
        step(1);
        soft_reset = 1'h0;
        chk(12'(lockstep_mismatch), 12'h000);
        frame_active = 1'h1;
        row_active = 1'h1;
        found = 1'h0;
        for (int c = 0; c < 64; c++) begin
            step(1);
            sh = {sh[62:0], serial_video_pos};
            chk(12'(serial_video_neg), 12'(!serial_video_pos));
            if (c > 17 && sh[17:0] === WORD) found = 1'h1;
        end
        chk(12'(found), 12'h001);
        chk(12'({video_data, frame_strobe_out, row_strobe_out}), 12'hFFF);
        pixel_in = 10'h2A5;
        step(1);
        chk(12'({video_data, frame_strobe_out, row_strobe_out}), 12'hA97);
        ssrs_host_model_inst.set_standby(1'h1);
        step(5);
        chk(12'({in_standby, video_oe}), 12'h001);
        frame_active = 1'h0;
        row_active = 1'h0;
        step(1);
        chk(12'({in_standby, video_oe, bus_respond_en}), 12'h004);
        chk(12'({serial_oe, standby_locked}), 12'h000);
        step(1);
        chk(12'({video_data, frame_strobe_out}), 12'h000);
        ssrs_host_model_inst.set_standby(1'h0);
        step(1);
        chk(12'({in_standby, video_oe}), 12'h001);
        stereo_en = 1'h0;
        step(2);
        chk(12'({serial_oe, serial_video_pos}), 12'h000);
        stereo_en = 1'h1;
        frame_active = 1'h1;
        step(3);
        frame_active = 1'h0;
        repeat (6) begin
            row_tick = 1'h1;
            step(1);
            row_tick = 1'h0;
            step(3);
        end
        ssrs_host_model_inst.set_standby(1'h1);
        step(3);
        ssrs_host_model_inst.set_standby(1'h0);
        soft_reset = 1'h1;
        frame_active = 1'h1;
        step(1);
        soft_reset = 1'h0;
        step(2);
        chk(12'({standby_locked, frame_strobe_out}), 12'h002);
        ssrs_host_model_inst.hw_reset(4);
        step(1);
        chk(12'({standby_locked, in_standby}), 12'h000);
        tally_and_finish();
    end
    initial begin
        step(5000);
        miscompares++;
        tally_and_finish();
    end
endmodule
